// >>> gpib_event_status_one.sv
// file: event status register, its clear rules, dac holdoff and interrupt
// assumes: the bus state machines drive the state inputs on hclk;
// cmd_accept and data_accept are one-cycle pulses per byte

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - read-only eight-bit event status at index 0x02, resets to zero
// - each status bit can raise the interrupt when its mask bit is set
// - commands 0x00-0x5f primary, 0x60-0x7f secondary, top data line ignored
// - with capture enabled, undefined primary command sets the pass-through flag
// - while talk or listen addressed, extra low commands also count undefined
// - after an undefined primary, any secondary in ACDS sets pass-through
// - pass-through set holds off DAC until software writes accept or reject
// - enabled holdoff options matching their command also set pass-through
// - pass-through clears on command register read, or on status read with select bit clear
// - command register read clears pass-through; mask clear also disables detection
// - extended dual addressing: secondary after own address sets address flag, holdoff
// - address flag clears by accept/reject with select set, else status read
// - trigger flag on GET when listen addressed; cleared by aux or read with select
// - end flag on EOI, terminator match, or newline while listener active
// - device clear flag on DCL, or SDC when listen addressed
// - error flag when source tries sending with no listeners present
// - data-out flag while talker active and in source generate state with nothing to send
// - data-in flag on byte accepted in SPMS and LACS, outside continuous holdoff
// - data-in clears on leaving SPMS or release-holdoff during a holdoff
// - status read with select clear clears end, clear, error, out, in flags
// - interrupt is OR of flags and masks, gated by global enable
module gpib_event_status_one (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic cmd_accept,
	input wire logic [7:0] bus_byte,
	input wire logic data_accept,
	input wire logic eoi,
	input wire logic tads,
	input wire logic lads,
	input wire logic tpas,
	input wire logic lpas,
	input wire logic lacs,
	input wire logic tacs,
	input wire logic sgns,
	input wire logic spms,
	input wire logic sdys,
	input wire logic t1,
	input wire logic shas,
	input wire logic rfd,
	input wire logic extdac,
	input wire logic nba,
	input wire logic dav,
	input wire logic atn,
	input wire logic continuous_holdoff,
	input wire logic holdoff_active,
	output logic dac_holdoff,
	output logic irq
);

	//////////////////////////////////////////////////////////////////////////
	// bus slave

	reg_access_if rbus ();

	ahb_reg_slave u_slave (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hwdata(hwdata),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.bus(rbus)
	);

	//////////////////////////////////////////////////////////////////////////
	// command decode

	logic primary, secondary, undefined;
	logic is_get, is_sdc, is_dcl, is_tag, is_lag, is_unt, is_unl;

	command_classify u_classify (
		.cmd_byte(bus_byte),
		.addressed(tads | lads),
		.primary(primary),
		.secondary(secondary),
		.undefined(undefined),
		.is_get(is_get),
		.is_sdc(is_sdc),
		.is_dcl(is_dcl),
		.is_tag(is_tag),
		.is_lag(is_lag),
		.is_unt(is_unt),
		.is_unl(is_unl)
	);

	//////////////////////////////////////////////////////////////////////////
	// software registers

	logic [7:0] status_ff, nxt_status;
	logic [7:0] mask_ff, nxt_mask;
	logic [10:0] cfg_ff, nxt_cfg;
	logic [7:0] term_ff, nxt_term;
	logic [7:0] addr_mode_ff, nxt_addr_mode;
	logic [7:0] pass_cmd_ff, nxt_pass_cmd;
	logic last_undef_ff, nxt_last_undef;
	logic holdoff_ff, nxt_holdoff;

	function automatic logic wr_at(input logic [5:0] idx);
		wr_at = rbus.wr_stb && (rbus.wr_idx == idx);
	endfunction

	function automatic logic rd_at(input logic [5:0] idx);
		rd_at = rbus.rd_stb && (rbus.rd_idx == idx);
	endfunction

	logic sel, cap_en, aux_wr;
	logic aux_accept, aux_reject, aux_clr_trig, aux_clr_term, aux_clr_dc, aux_clear_nolistener_aux;
	logic aux_release, rd_status, rd_pass;

	assign sel = cfg_ff[event_status_pkg::CFG_STATUS_CLEAR_SELECT];
	// clearing the mask bit also switches undefined-command detection off
	assign cap_en = cfg_ff[event_status_pkg::CFG_CAPTURE_ENABLE]
		& mask_ff[event_status_pkg::BIT_PASS];
	assign aux_wr = wr_at(event_status_pkg::AUX_CMD_IDX);
	assign aux_accept = aux_wr && (rbus.wdata[7:0] == event_status_pkg::AUX_ACCEPT);
	assign aux_reject = aux_wr && (rbus.wdata[7:0] == event_status_pkg::AUX_REJECT);
	assign aux_clr_trig = aux_wr && (rbus.wdata[7:0] == event_status_pkg::AUX_CLEAR_TRIGGER);
	assign aux_clr_term = aux_wr && (rbus.wdata[7:0] == event_status_pkg::AUX_CLEAR_TERMINATOR);
	assign aux_clr_dc = aux_wr && (rbus.wdata[7:0] == event_status_pkg::AUX_CLEAR_DEVCLEAR);
	assign aux_clear_nolistener_aux = aux_wr && (rbus.wdata[7:0] == event_status_pkg::AUX_CLEAR_NOLISTENER);
	assign aux_release = aux_wr && (rbus.wdata[7:0] == event_status_pkg::AUX_RELEASE_HOLDOFF);
	assign rd_status = rd_at(event_status_pkg::EVENT_STATUS_IDX);
	assign rd_pass = rd_at(event_status_pkg::PASS_CMD_IDX);

	always_comb begin
		nxt_mask = wr_at(event_status_pkg::EVENT_MASK_IDX) ? rbus.wdata[7:0] : mask_ff;
		nxt_cfg = wr_at(event_status_pkg::CONFIG_IDX) ? rbus.wdata[10:0] : cfg_ff;
		nxt_term = wr_at(event_status_pkg::TERM_MATCH_IDX) ? rbus.wdata[7:0] : term_ff;
		nxt_addr_mode = wr_at(event_status_pkg::ADDR_MODE_IDX) ? rbus.wdata[7:0]
			: addr_mode_ff;
	end

	always_comb begin
		rbus.rdata = 32'h0000_0000;
		case (rbus.rd_idx)
			event_status_pkg::EVENT_STATUS_IDX: rbus.rdata[7:0] = status_ff;
			event_status_pkg::EVENT_MASK_IDX: rbus.rdata[7:0] = mask_ff;
			event_status_pkg::PASS_CMD_IDX: rbus.rdata[7:0] = pass_cmd_ff;
			event_status_pkg::CONFIG_IDX: rbus.rdata[10:0] = cfg_ff;
			event_status_pkg::TERM_MATCH_IDX: rbus.rdata[7:0] = term_ff;
			event_status_pkg::ADDR_MODE_IDX: rbus.rdata[7:0] = addr_mode_ff;
			default: rbus.rdata = 32'h0000_0000;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// event detection

	logic undef_cmd, pass_set, addr_pass_set, trig_set, end_set, dc_set;
	logic err_set, out_set, out_clr, in_set, in_clr, byte_end;

	always_comb begin
		undef_cmd = cmd_accept & primary & undefined & cap_en;
		pass_set = undef_cmd
			| (cmd_accept & secondary & last_undef_ff & cap_en)
			| (cmd_accept & cfg_ff[event_status_pkg::CFG_HOLDOFF_ON_TRIGGER]
				& is_get & lads)
			| (cmd_accept & cfg_ff[event_status_pkg::CFG_HOLDOFF_ON_CLEAR]
				& (is_sdc | is_dcl))
			| (cmd_accept & cfg_ff[event_status_pkg::CFG_HOLDOFF_ON_TALK_ADDR]
				& is_tag & ~is_unt)
			| (cmd_accept & cfg_ff[event_status_pkg::CFG_HOLDOFF_ON_LISTEN_ADDR]
				& is_lag & ~is_unl)
			| (cmd_accept & cfg_ff[event_status_pkg::CFG_HOLDOFF_ON_UNADDRESS]
				& (is_unt | is_unl))
			| (cmd_accept & cfg_ff[event_status_pkg::CFG_HOLDOFF_ON_ALL_COMMANDS]);
		addr_pass_set = cmd_accept & secondary & (tpas | lpas)
			& (addr_mode_ff == event_status_pkg::ADDR_MODE_EXT_DUAL);
		trig_set = cmd_accept & is_get & lads;
		dc_set = cmd_accept & (is_dcl | (is_sdc & lads));
		byte_end = eoi
			| ((bus_byte == term_ff) & cfg_ff[event_status_pkg::CFG_STRING_MATCH_END_ENABLE])
			| ((bus_byte == event_status_pkg::NEWLINE_BYTE)
				& cfg_ff[event_status_pkg::CFG_NEWLINE_END_ENABLE]);
		end_set = data_accept & lacs & byte_end;
		err_set = sdys & t1 & ~shas & rfd & extdac;
		out_set = tacs & sgns & ~nba;
		out_clr = ~tacs | ~sgns | nba;
		in_set = ~continuous_holdoff & spms & lacs & dav & ~atn;
		in_clr = ~spms | (aux_release & holdoff_active);
	end

	//////////////////////////////////////////////////////////////////////////
	// flag update: every set wins over a clear in the same cycle

	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		flag_next = set | (cur & ~clr);
	endfunction

	always_comb begin
		nxt_status = status_ff;
		// command register read clears in either select mode
		nxt_status[event_status_pkg::BIT_PASS] = flag_next(status_ff[event_status_pkg::BIT_PASS],
			pass_set, (rd_status & ~sel) | rd_pass
			| ~mask_ff[event_status_pkg::BIT_PASS]);
		nxt_status[event_status_pkg::BIT_ADDR_PASS] = flag_next(
			status_ff[event_status_pkg::BIT_ADDR_PASS], addr_pass_set,
			(sel & (aux_accept | aux_reject)) | (rd_status & ~sel));
		nxt_status[event_status_pkg::BIT_TRIG] = flag_next(status_ff[event_status_pkg::BIT_TRIG],
			trig_set, aux_clr_trig | (rd_status & sel));
		nxt_status[event_status_pkg::BIT_END] = flag_next(status_ff[event_status_pkg::BIT_END],
			end_set, aux_clr_term | (rd_status & ~sel));
		nxt_status[event_status_pkg::BIT_DEV_CLEAR] = flag_next(
			status_ff[event_status_pkg::BIT_DEV_CLEAR], dc_set,
			aux_clr_dc | (rd_status & ~sel));
		nxt_status[event_status_pkg::BIT_ERROR] = flag_next(status_ff[event_status_pkg::BIT_ERROR],
			err_set, aux_clear_nolistener_aux | (rd_status & ~sel));
		nxt_status[event_status_pkg::BIT_DATA_OUT] = flag_next(
			status_ff[event_status_pkg::BIT_DATA_OUT], out_set,
			out_clr | (rd_status & ~sel));
		nxt_status[event_status_pkg::BIT_DATA_IN] = flag_next(
			status_ff[event_status_pkg::BIT_DATA_IN], in_set,
			in_clr | (rd_status & ~sel));
	end

	//////////////////////////////////////////////////////////////////////////
	// pass-through command capture and holdoff

	always_comb begin
		nxt_last_undef = last_undef_ff;
		if (cmd_accept && primary) begin
			nxt_last_undef = undefined & cap_en;
		end
		nxt_pass_cmd = pass_cmd_ff;
		if (pass_set) begin
			nxt_pass_cmd = bus_byte;
		end
		// holdoff stays until software answers, so no command is overrun
		nxt_holdoff = holdoff_ff;
		if (pass_set || addr_pass_set) begin
			nxt_holdoff = 1'b1;
		end else if (aux_accept || aux_reject) begin
			nxt_holdoff = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_ff <= event_status_pkg::EVENT_STATUS_RESET;
			mask_ff <= event_status_pkg::EVENT_MASK_RESET;
			cfg_ff <= event_status_pkg::CONFIG_RESET;
			term_ff <= event_status_pkg::BYTE_RESET;
			addr_mode_ff <= event_status_pkg::BYTE_RESET;
			pass_cmd_ff <= event_status_pkg::BYTE_RESET;
			last_undef_ff <= 1'b0;
			holdoff_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			cfg_ff <= nxt_cfg;
			term_ff <= nxt_term;
			addr_mode_ff <= nxt_addr_mode;
			pass_cmd_ff <= nxt_pass_cmd;
			last_undef_ff <= nxt_last_undef;
			holdoff_ff <= nxt_holdoff;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs

	assign dac_holdoff = holdoff_ff;
	assign irq = cfg_ff[event_status_pkg::CFG_GLOBAL_INTERRUPT_ENABLE]
		& (|(status_ff & mask_ff));

endmodule

// >>> event_status_pkg.sv
// package: constants shared by the event status block and its command decoder
// assumes: ahb-lite register bus, one 100 MHz clock
package event_status_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] EVENT_STATUS_IDX = 6'h02;
	localparam logic [5:0] EVENT_MASK_IDX = 6'h03;
	localparam logic [5:0] PASS_CMD_IDX = 6'h04;
	localparam logic [5:0] AUX_CMD_IDX = 6'h05;
	localparam logic [5:0] CONFIG_IDX = 6'h06;
	localparam logic [5:0] TERM_MATCH_IDX = 6'h07;
	localparam logic [5:0] ADDR_MODE_IDX = 6'h08;

	localparam logic [7:0] EVENT_STATUS_RESET = 8'h00;
	localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
	localparam logic [10:0] CONFIG_RESET = 11'h000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// event status bit positions
	localparam int BIT_PASS = 7;
	localparam int BIT_ADDR_PASS = 6;
	localparam int BIT_TRIG = 5;
	localparam int BIT_END = 4;
	localparam int BIT_DEV_CLEAR = 3;
	localparam int BIT_ERROR = 2;
	localparam int BIT_DATA_OUT = 1;
	localparam int BIT_DATA_IN = 0;

	// config register bit positions
	localparam int CFG_STATUS_CLEAR_SELECT = 0;
	localparam int CFG_CAPTURE_ENABLE = 1;
	localparam int CFG_HOLDOFF_ON_TRIGGER = 2;
	localparam int CFG_HOLDOFF_ON_CLEAR = 3;
	localparam int CFG_HOLDOFF_ON_TALK_ADDR = 4;
	localparam int CFG_HOLDOFF_ON_LISTEN_ADDR = 5;
	localparam int CFG_HOLDOFF_ON_UNADDRESS = 6;
	localparam int CFG_HOLDOFF_ON_ALL_COMMANDS = 7;
	localparam int CFG_STRING_MATCH_END_ENABLE = 8;
	localparam int CFG_NEWLINE_END_ENABLE = 9;
	localparam int CFG_GLOBAL_INTERRUPT_ENABLE = 10;

	// auxiliary command codes
	localparam logic [7:0] AUX_ACCEPT = 8'h01;
	localparam logic [7:0] AUX_REJECT = 8'h02;
	localparam logic [7:0] AUX_CLEAR_TRIGGER = 8'h03;
	localparam logic [7:0] AUX_CLEAR_TERMINATOR = 8'h04;
	localparam logic [7:0] AUX_CLEAR_DEVCLEAR = 8'h05;
	localparam logic [7:0] AUX_CLEAR_NOLISTENER = 8'h06;
	localparam logic [7:0] AUX_RELEASE_HOLDOFF = 8'h07;

	// bus command bytes (seven bits, top data line dropped), then the eight-bit address mode and newline values
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_UNL = 7'h3f;
	localparam logic [6:0] CMD_UNT = 7'h5f;
	localparam logic [6:0] CMD_PRIMARY_LAST = 7'h5f;
	localparam logic [7:0] ADDR_MODE_EXT_DUAL = 8'h33;
	localparam logic [7:0] NEWLINE_BYTE = 8'h0a;

endpackage

// >>> reg_access_if.sv
// interface: register strobes between the bus slave and the event logic
// assumes: both ends on hclk; strobes are one-cycle pulses
interface reg_access_if;
	logic rd_stb;
	logic [5:0] rd_idx;
	logic [31:0] rdata;
	logic wr_stb;
	logic [5:0] wr_idx;
	logic [31:0] wdata;

	modport slave (output rd_stb, output rd_idx, input rdata, output wr_stb, output wr_idx,
		output wdata);
	modport regs (input rd_stb, input rd_idx, output rdata, input wr_stb, input wr_idx,
		input wdata);
endinterface

// >>> ahb_reg_slave.sv
// file: ahb-lite slave, zero wait states, word accesses only
// assumes: single slave, its hreadyout is the bus hready
module ahb_reg_slave (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	reg_access_if.slave bus
);

	logic take;
	logic wr_pend_ff, nxt_wr_pend;
	logic [5:0] wr_idx_ff, nxt_wr_idx;
	logic [31:0] hrdata_ff, nxt_hrdata;

	// read data is sampled in the address phase so any read-clear lands after it
	assign take = hsel & htrans[1] & hready & (hsize == 3'h2);
	assign bus.rd_stb = take & ~hwrite;
	assign bus.rd_idx = haddr[7:2];
	assign bus.wr_stb = wr_pend_ff;
	assign bus.wr_idx = wr_idx_ff;
	assign bus.wdata = hwdata;
	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb begin
		nxt_wr_pend = take & hwrite;
		nxt_wr_idx = take ? haddr[7:2] : wr_idx_ff;
		nxt_hrdata = (take & ~hwrite) ? bus.rdata : hrdata_ff;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 6'h00;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			wr_idx_ff <= nxt_wr_idx;
			hrdata_ff <= nxt_hrdata;
		end
	end

endmodule

// >>> command_classify.sv
// file: combinational classification of one bus command byte
// assumes: byte is valid only while the caller says so
module command_classify (
	input wire logic [7:0] cmd_byte,
	input wire logic addressed,
	output logic primary,
	output logic secondary,
	output logic undefined,
	output logic is_get,
	output logic is_sdc,
	output logic is_dcl,
	output logic is_tag,
	output logic is_lag,
	output logic is_unt,
	output logic is_unl
);

	logic [6:0] c;

	assign c = cmd_byte[6:0];

	always_comb begin
		primary = (c <= event_status_pkg::CMD_PRIMARY_LAST);
		secondary = ~primary;
		undefined = 1'b0;
		case (c)
			7'h10, 7'h12, 7'h13, 7'h16, 7'h17, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e,
			7'h1f: undefined = 1'b1;
			7'h00, 7'h02, 7'h03, 7'h06, 7'h07, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e,
			7'h0f: undefined = addressed;
			default: undefined = 1'b0;
		endcase
		is_get = (c == event_status_pkg::CMD_GET);
		is_sdc = (c == event_status_pkg::CMD_SDC);
		is_dcl = (c == event_status_pkg::CMD_DCL);
		is_lag = (c[6:5] == 2'h1);
		is_tag = (c[6:5] == 2'h2);
		is_unl = (c == event_status_pkg::CMD_UNL);
		is_unt = (c == event_status_pkg::CMD_UNT);
	end

endmodule

// >>> gpib_event_status_one_assertions.sv
// file: port-level checks for the event status block
// assumes: one hclk domain; bound onto the top module below
module gpib_event_status_one_assertions (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic cmd_accept,
	input wire logic dac_holdoff,
	input wire logic irq
);
	logic rd_go;
	logic nxt_wr_phase;
	logic wr_phase_ff;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	assign rd_go = hsel & htrans[1] & hready & (hsize == 3'h2) & !hwrite;
	always_comb begin
		nxt_wr_phase = hsel & htrans[1] & hready & (hsize == 3'h2) & hwrite;
	end
	// a write data phase is the only thing allowed to drop the holdoff
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_phase_ff <= 1'b0;
		end else begin
			wr_phase_ff <= nxt_wr_phase;
		end
	end
	////////////////////////////////////////
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("hreadyout low");
	property p_okay; !hresp; endproperty
	a_okay: assert property (p_okay) else $error("hresp not okay");
	property p_hold_cause; $rose(dac_holdoff) |-> $past(cmd_accept); endproperty
	a_hold_cause: assert property (p_hold_cause) else $error("holdoff without command");
	property p_hold_release; $fell(dac_holdoff) |-> $past(wr_phase_ff); endproperty
	a_hold_release: assert property (p_hold_release) else $error("holdoff dropped alone");
	property p_read_stands; !$past(rd_go) |-> $stable(hrdata); endproperty
	a_read_stands: assert property (p_read_stands) else $error("hrdata moved");
	property p_unmapped; rd_go && haddr[7:2] == 6'h00 |=> hrdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_aux_zero;
		rd_go && haddr[7:2] == event_status_pkg::AUX_CMD_IDX |=> hrdata == 32'h0;
	endproperty
	a_aux_zero: assert property (p_aux_zero) else $error("aux read not zero");
	property p_upper_zero; rd_go |=> hrdata[31:11] == 21'h0; endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	cover property ($rose(dac_holdoff));
	cover property ($fell(dac_holdoff));
	cover property ($rose(irq));
endmodule
bind gpib_event_status_one gpib_event_status_one_assertions i_chk (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp, .cmd_accept,
	.dac_holdoff, .irq);

// >>> gpib_controller_model.sv
// file: behavioural system controller and talker on the far side
// assumes: tasks are called by the bench right after a rising edge
module gpib_controller_model (
	input wire logic hclk,
	input wire logic dac_holdoff,
	output logic cmd_accept,
	output logic [7:0] bus_byte,
	output logic data_accept,
	output logic eoi,
	output logic dav,
	output logic atn
);
	timeunit 1ns;
	timeprecision 1ps;
	int hangs = 0;
	initial begin
		{cmd_accept, data_accept, eoi, dav, atn} = 5'h0;
		bus_byte = 8'h00;
	end
	// one byte: c high sends a command, low a data byte; afterwards the data lines show the inverted byte
	task automatic drive(input logic c, input logic [7:0] b, input logic e);
		int n;
		for (n = 0; n < 40 && c && dac_holdoff !== 1'b0; n++) begin
			@(posedge hclk);
		end
		hangs += int'(c && dac_holdoff !== 1'b0);
		@(posedge hclk);
		atn <= c;
		dav <= 1'b1;
		cmd_accept <= c;
		data_accept <= !c;
		bus_byte <= b;
		eoi <= e;
		@(posedge hclk);
		{cmd_accept, data_accept, dav, eoi} <= 4'h0;
		bus_byte <= ~b;
		@(posedge hclk);
	endtask
endmodule

// >>> tb_gpib_event_status_one.sv
// file: self-checking bench for the event status block
// assumes: bench is the ahb-lite master; the controller model drives bus events
module tb_gpib_event_status_one;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ad_st = {event_status_pkg::EVENT_STATUS_IDX, 2'h0};
	localparam logic [7:0] ad_mask = {event_status_pkg::EVENT_MASK_IDX, 2'h0};
	localparam logic [7:0] ad_pass = {event_status_pkg::PASS_CMD_IDX, 2'h0};
	localparam logic [7:0] ad_cfg = {event_status_pkg::CONFIG_IDX, 2'h0};
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, rv;
	logic hreadyout, hresp, cmd_accept, data_accept, eoi, dav, atn, dac_holdoff, irq;
	logic [7:0] bus_byte;
	logic tads = 1'b0, lads = 1'b0, tpas = 1'b0, lpas = 1'b0, lacs = 1'b0, tacs = 1'b0;
	logic sgns = 1'b0, spms = 1'b0, sdys = 1'b0, t1 = 1'b0, shas = 1'b0, rfd = 1'b0;
	logic extdac = 1'b0, nba = 1'b0, continuous_holdoff = 1'b0, holdoff_active = 1'b0;
	int miscompares = 0;
	int samples_checked = 0;
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	gpib_event_status_one i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready, .hwdata, .hrdata, .hreadyout, .hresp, .cmd_accept, .bus_byte, .data_accept,
		.eoi, .tads, .lads, .tpas, .lpas, .lacs, .tacs, .sgns, .spms, .sdys, .t1, .shas, .rfd,
		.extdac, .nba, .dav, .atn, .continuous_holdoff, .holdoff_active, .dac_holdoff, .irq);
	gpib_controller_model i_ctl (.hclk, .dac_holdoff, .cmd_accept, .bus_byte, .data_accept,
		.eoi, .dav, .atn);
	////////////////////////////////////////
	task automatic complete_run();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_ready();
		for (int n = 0; n < 20; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) begin
				return;
			end
		end
		miscompares++;
		complete_run();
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rv = hrdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	// one spare edge so the write has landed before anything is looked at
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		@(posedge hclk);
	endtask
	task automatic aux(input logic [7:0] c);
		wr({event_status_pkg::AUX_CMD_IDX, 2'h0}, {24'h0, c});
	endtask
	task automatic no_listener();
		{sdys, t1, rfd, extdac, shas} <= 5'b11110;
		@(posedge hclk);
		{sdys, t1, rfd, extdac, shas} <= 5'h0;
		@(posedge hclk);
	endtask
	////////////////////////////////////////
	task automatic s_reset();
		wr(ad_st, 32'hff);
		rd_chk(ad_st, 32'h0);
		rd_chk(ad_mask, 32'h0);
		rd_chk(8'h00, 32'h0);
		chk(32'({dac_holdoff, irq}), 32'h0);
	endtask
	task automatic s_undefined();
		logic [15:0] t [0:17];
		t = '{16'h0110, 16'h0112, 16'h0113, 16'h0116, 16'h0117, 16'h011a, 16'h011b, 16'h011c,
			16'h011d, 16'h011e, 16'h011f, 16'h0002, 16'h0060, 16'h1102, 16'h0160, 16'h2107,
			16'h019a, 16'h0011};
		wr(ad_cfg, 32'h402);
		wr(ad_mask, 32'h80);
		for (int i = 0; i < 18; i++) begin
			lads <= t[i][12];
			tads <= t[i][13];
			i_ctl.drive(1'b1, t[i][7:0], 1'b0);
			chk(32'(dac_holdoff), 32'(t[i][8]));
			chk(32'(irq), 32'(t[i][8]));
			rd_chk(ad_st, {24'h0, t[i][8], 7'h0});
			chk(32'(irq), 32'h0);
			if (t[i][8]) begin
				xfer(1'b0, ad_pass, 32'h0);
				chk(rv & 32'h7f, {25'h0, t[i][6:0]});
				aux(event_status_pkg::AUX_ACCEPT);
				chk(32'(dac_holdoff), 32'h0);
			end
		end
		wr(ad_cfg, 32'h403);
		i_ctl.drive(1'b1, 8'h10, 1'b0);
		wr(ad_mask, 32'h0);
		rd_chk(ad_st, 32'h0);
		aux(event_status_pkg::AUX_ACCEPT);
		i_ctl.drive(1'b1, 8'h12, 1'b0);
		chk(32'(dac_holdoff), 32'h0);
	endtask
	task automatic s_options();
		logic [31:0] t [0:6];
		t = '{32'h0005_8008, 32'h0009_0004, 32'h0011_0041, 32'h0021_0021, 32'h0041_005f,
			32'h0041_003f, 32'h0081_0015};
		wr(ad_mask, 32'h80);
		for (int i = 0; i < 7; i++) begin
			lads <= t[i][15];
			wr(ad_cfg, {16'h0, t[i][31:16]});
			i_ctl.drive(1'b1, t[i][7:0], 1'b0);
			chk(32'(dac_holdoff), 32'h1);
			rd_chk(ad_st, {24'h0, 2'h2, t[i][15], 5'h0});
			rd_chk(ad_pass, {24'h0, t[i][7:0]});
			rd_chk(ad_st, 32'h0);
			aux(event_status_pkg::AUX_ACCEPT);
			chk(32'(dac_holdoff), 32'h0);
		end
	endtask
	task automatic s_select_clear();
		wr(ad_cfg, 32'h0);
		lads <= 1'b1;
		lacs <= 1'b1;
		i_ctl.drive(1'b1, {1'b0, event_status_pkg::CMD_GET}, 1'b0);
		i_ctl.drive(1'b1, {1'b0, event_status_pkg::CMD_DCL}, 1'b0);
		i_ctl.drive(1'b0, 8'h41, 1'b1);
		tacs <= 1'b1;
		sgns <= 1'b1;
		no_listener();
		rd_chk(ad_st, 32'h3e);
		rd_chk(ad_st, 32'h22);
		nba <= 1'b1;
		@(posedge hclk);
		rd_chk(ad_st, 32'h20);
		aux(event_status_pkg::AUX_CLEAR_TRIGGER);
		rd_chk(ad_st, 32'h0);
		{tacs, sgns, nba} <= 3'h0;
	endtask
	task automatic s_select_set();
		wr(ad_cfg, 32'h301);
		wr({event_status_pkg::TERM_MATCH_IDX, 2'h0}, 32'h55);
		i_ctl.drive(1'b1, {1'b0, event_status_pkg::CMD_GET}, 1'b0);
		i_ctl.drive(1'b1, {1'b0, event_status_pkg::CMD_SDC}, 1'b0);
		i_ctl.drive(1'b0, 8'h55, 1'b0);
		rd_chk(ad_st, 32'h38);
		rd_chk(ad_st, 32'h18);
		aux(event_status_pkg::AUX_CLEAR_TERMINATOR);
		rd_chk(ad_st, 32'h08);
		aux(event_status_pkg::AUX_CLEAR_DEVCLEAR);
		i_ctl.drive(1'b0, event_status_pkg::NEWLINE_BYTE, 1'b0);
		rd_chk(ad_st, 32'h10);
		aux(event_status_pkg::AUX_CLEAR_TERMINATOR);
		no_listener();
		rd_chk(ad_st, 32'h04);
		aux(event_status_pkg::AUX_CLEAR_NOLISTENER);
		spms <= 1'b1;
		continuous_holdoff <= 1'b1;
		i_ctl.drive(1'b0, 8'h33, 1'b0);
		rd_chk(ad_st, 32'h0);
		continuous_holdoff <= 1'b0;
		i_ctl.drive(1'b0, 8'h33, 1'b0);
		rd_chk(ad_st, 32'h01);
		holdoff_active <= 1'b1;
		aux(event_status_pkg::AUX_RELEASE_HOLDOFF);
		rd_chk(ad_st, 32'h0);
		i_ctl.drive(1'b0, 8'h33, 1'b0);
		spms <= 1'b0;
		@(posedge hclk);
		rd_chk(ad_st, 32'h0);
		{lads, lacs, holdoff_active} <= 3'h0;
	endtask
	task automatic s_addr_pass();
		wr({event_status_pkg::ADDR_MODE_IDX, 2'h0}, {24'h0, event_status_pkg::ADDR_MODE_EXT_DUAL});
		lpas <= 1'b1;
		i_ctl.drive(1'b1, 8'h61, 1'b0);
		chk(32'(dac_holdoff), 32'h1);
		rd_chk(ad_st, 32'h40);
		aux(event_status_pkg::AUX_REJECT);
		rd_chk(ad_st, 32'h0);
		wr(ad_cfg, 32'h0);
		// talk side of the address pair must raise the flag as well
		lpas <= 1'b0;
		tpas <= 1'b1;
		i_ctl.drive(1'b1, 8'h61, 1'b0);
		chk(32'(dac_holdoff), 32'h1);
		rd_chk(ad_st, 32'h40);
		rd_chk(ad_st, 32'h0);
		aux(event_status_pkg::AUX_ACCEPT);
		wr({event_status_pkg::ADDR_MODE_IDX, 2'h0}, 32'h0);
		i_ctl.drive(1'b1, 8'h61, 1'b0);
		chk(32'(dac_holdoff), 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		s_reset();
		s_undefined();
		s_options();
		s_select_clear();
		s_select_set();
		s_addr_pass();
		chk(32'(i_ctl.hangs), 32'h0);
		complete_run();
	end
endmodule
